// ### core/sar_pkg.sv
// Constants, state codes and carrier types of the SAR converter serial readout.
// Assumes a single system clock; every pin-side value is synchronised in the core.
package sar_pkg;

  // Result word width and bit-index arithmetic.
  localparam int RES_BITS = 12;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_TOP = 4'hb;
  localparam logic [IDX_W-1:0] IDX_BOTTOM = 4'h0;
  localparam logic [IDX_W-1:0] IDX_REV_FIRST = 4'h1;
  localparam logic [IDX_W-1:0] IDX_REV_END = 4'hc;
  localparam logic [IDX_W-1:0] IDX_STEP = 4'h1;

  // Reset values of the converter outputs, and the one bit that seeds the first trial code.
  localparam logic [RES_BITS-1:0] CODE_CLEAR = 12'h000;
  localparam logic [RES_BITS-1:0] CODE_ONE = 12'h001;
  localparam logic NULL_BIT = 1'b0;

  // Depth of the result buffer toward the on-chip consumer.
  localparam int FIFO_DEPTH = 16;

  // Conversion sequencer states, one-hot.
  typedef enum logic [4:0] {
    SAR_OFF    = 5'h01,
    SAR_SAMPLE = 5'h02,
    SAR_CONV   = 5'h04,
    SAR_REV    = 5'h08,
    SAR_DONE   = 5'h10
  } sar_state_t;

  // One finished conversion result.
  typedef struct packed {
    logic [RES_BITS-1:0] code;
  } sar_result_t;

endpackage

// ### core/sar_adc_serial_readout.sv
// Digital control and serial readout of a 12-bit successive-approximation converter,
// with a result buffer that hands finished words to on-chip logic.
// Assumes select and data clock arrive from a host pin, and the comparator output from
// the analog core; all three are asynchronous to mclk and pass two flip-flops first.
`timescale 1ns/10ps
`default_nettype none

// Result buffer; the output stage is a register so that its outputs come from flops.
module sar_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_DEPTH = (PW+1)'(DEPTH);
  localparam logic [PW:0] CNT_ONE = (PW+1)'(1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Full stalls the writer; the output stage refills whenever it is free or being taken.
  assign in_ready = (count_reg != CNT_DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid || out_ready);

  // Storage array, written only on an accepted push.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
      end
      if (push && !pop) begin
        count_reg <= count_reg + CNT_ONE;
      end else if (pop && !push) begin
        count_reg <= count_reg - CNT_ONE;
      end
    end
  end

  // Registered output stage.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// Summary of operation
// - Select low means operating; select high means shutdown. A select fall with the buffer full leaves the core in shutdown.
// - Every conversion yields exactly twelve result bits.
// - Each output bit is valid at the data clock rising edge.
// - Output stays off after select falls, enabled at the second clock pulse.
// - Enabled output sends one null bit, then twelve result bits.
// - The host data clock alone paces transfer and conversion steps.
// - Input is captured at conversion start, then disconnected until complete.
// - Result leaves most significant bit first.
// - Shifted bits belong to the conversion running in the same cycle.
// - Further clocks resend the result least significant bit first.
// - Each output bit is launched on a data clock falling edge.
// - Input is sampled during the first 1.5 to 2.0 clock periods.
// - After the top bit repeats, output floats and clocks are ignored.
// - A conversion starts only when select rises and then falls again.
module sar_adc_serial_readout (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic select_shutdown_n,
  input wire logic transfer_conv_clock,
  input wire logic comp_in,
  output logic serial_out,
  output logic serial_oe_n,
  output logic sample_en,
  output logic [sar_pkg::RES_BITS-1:0] dac_code,
  output logic shutdown,
  output sar_pkg::sar_result_t res_word,
  output logic res_valid,
  input wire logic res_ready
);
  import sar_pkg::*;

  logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic comp_s1_reg, comp_s2_reg;
  logic sel_fall, clk_rise, clk_fall;
  sar_state_t state_reg;
  logic [IDX_W-1:0] bit_idx_reg;
  logic first_fall_reg;
  logic [RES_BITS-1:0] code_reg;
  logic dout_reg, oe_n_reg, sample_reg;
  logic push;
  logic fifo_in_ready;
  sar_result_t push_word;

  // Two-flop synchronisers plus a third stage used only for edge detection.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_s3_reg <= 1'b1;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= select_shutdown_n;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      clk_s1_reg <= transfer_conv_clock;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      comp_s1_reg <= comp_in;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  // Conversion and transfer steps are keyed to a data clock edge, the start to a select fall; mclk only samples them.
  assign clk_rise = clk_s2_reg && !clk_s3_reg;
  assign clk_fall = !clk_s2_reg && clk_s3_reg;
  assign sel_fall = !sel_s2_reg && sel_s3_reg;

  // The finished word is pushed at the fall that launches the bottom bit; a start without room is refused.
  assign push = (state_reg == SAR_CONV) && clk_fall && !sel_s2_reg && (bit_idx_reg == IDX_BOTTOM);
  assign push_word.code = code_reg;

  // Sequencer, serial output and successive-approximation register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SAR_OFF;
      bit_idx_reg <= IDX_TOP;
      first_fall_reg <= 1'b0;
      code_reg <= CODE_CLEAR;
      dout_reg <= NULL_BIT;
      oe_n_reg <= 1'b1;
      sample_reg <= 1'b0;
    end else if (sel_s2_reg) begin
      state_reg <= SAR_OFF;
      oe_n_reg <= 1'b1;
      sample_reg <= 1'b0;
    end else begin
      case (state_reg)
        SAR_OFF: begin
          if (sel_fall && fifo_in_ready) begin
            state_reg <= SAR_SAMPLE;
            sample_reg <= 1'b1;
            first_fall_reg <= 1'b0;
            code_reg <= CODE_CLEAR;
          end
        end
        SAR_SAMPLE: begin
          if (clk_fall) begin
            first_fall_reg <= 1'b1;
            if (first_fall_reg) begin
              state_reg <= SAR_CONV;
              sample_reg <= 1'b0;
              oe_n_reg <= 1'b0;
              dout_reg <= NULL_BIT;
              bit_idx_reg <= IDX_TOP;
              code_reg <= CODE_ONE << IDX_TOP;
            end
          end
        end
        SAR_CONV: begin
          // A rise keeps or drops the trial bit and sets the next trial bit.
          if (clk_rise) begin
            code_reg[bit_idx_reg] <= comp_s2_reg;
            if (bit_idx_reg != IDX_BOTTOM) begin
              code_reg[bit_idx_reg - IDX_STEP] <= 1'b1;
            end
          end else if (clk_fall) begin
            dout_reg <= code_reg[bit_idx_reg];
            if (bit_idx_reg == IDX_BOTTOM) begin
              state_reg <= SAR_REV;
              bit_idx_reg <= IDX_REV_FIRST;
            end else begin
              bit_idx_reg <= bit_idx_reg - IDX_STEP;
            end
          end
        end
        SAR_REV: begin
          if (clk_fall) begin
            if (bit_idx_reg == IDX_REV_END) begin
              state_reg <= SAR_DONE;
              oe_n_reg <= 1'b1;
            end else begin
              dout_reg <= code_reg[bit_idx_reg];
              bit_idx_reg <= bit_idx_reg + IDX_STEP;
            end
          end
        end
        SAR_DONE: begin
          oe_n_reg <= 1'b1;
        end
        default: begin
          state_reg <= SAR_OFF;
          oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Shutdown flag follows the sequencer one cycle later, as a registered output.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b1;
    end else begin
      shutdown <= (state_reg == SAR_OFF);
    end
  end

  assign serial_out = dout_reg;
  assign serial_oe_n = oe_n_reg;
  assign sample_en = sample_reg;
  assign dac_code = code_reg;

  // Result buffer; a full buffer holds off the next conversion rather than lose a word.
  sar_fifo #(
    .WIDTH($bits(sar_result_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_word)
  );

  // Checks on the sequencer, all in the mclk domain.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_select_high_off: assert property (sel_s2_reg |=> serial_oe_n && state_reg == SAR_OFF)
    else $error("select high did not float the output");
  a_quiet_sample: assert property (state_reg == SAR_SAMPLE |-> serial_oe_n && sample_en)
    else $error("output driven or input not tracking while sampling");
  a_enable_second: assert property (state_reg == SAR_SAMPLE && first_fall_reg && clk_fall && !sel_s2_reg
    |=> !serial_oe_n && serial_out == NULL_BIT && !sample_en)
    else $error("output not enabled with null bit at second fall");
  a_msb_order: assert property (state_reg == SAR_CONV && clk_fall && !sel_s2_reg
    |=> serial_out == $past(code_reg[bit_idx_reg]))
    else $error("wrong bit launched in forward order");
  a_lsb_repeat: assert property (state_reg == SAR_REV && clk_fall && !sel_s2_reg && bit_idx_reg != IDX_REV_END
    |=> serial_out == $past(code_reg[bit_idx_reg]) && !serial_oe_n)
    else $error("wrong bit launched in reverse order");
  a_launch_on_fall: assert property (!serial_oe_n && $past(!serial_oe_n) && $changed(serial_out)
    |-> $past(clk_fall))
    else $error("output changed without a data clock fall");
  a_hold_inputs: assert property (state_reg inside {SAR_CONV, SAR_REV, SAR_DONE} |-> !sample_en)
    else $error("input reconnected during conversion");
  a_push_last: assert property (push |-> fifo_in_ready ##1 state_reg == SAR_REV)
    else $error("result pushed at wrong point");
  a_done_float: assert property (state_reg == SAR_DONE |-> serial_oe_n ##1 state_reg != SAR_CONV)
    else $error("output driven after reverse sequence");
  a_start_fall: assert property ($rose(state_reg == SAR_SAMPLE) |-> $past(sel_fall))
    else $error("conversion started without select fall");

  c_full_cycle: cover property (state_reg == SAR_REV ##[1:1000] state_reg == SAR_DONE);
  c_abort_conv: cover property (state_reg == SAR_CONV && sel_s2_reg);
  c_buffer_full: cover property (!fifo_in_ready && sel_fall);
  c_word_out: cover property (res_valid && res_ready);

endmodule

`default_nettype wire

// ### dv/sar_host_model.sv
// Host-side model: drives select and data clock, stands in for the comparator, captures serial data.
// Assumes the converter core sits on the same mclk and is checked by the bench through the arrays.
`timescale 1ns/10ps
`default_nettype none

module sar_host_model
  import sar_pkg::*;
#(
  parameter int HALF = 40
) (
  input wire logic mclk,
  output logic select_shutdown_n,
  output logic transfer_conv_clock,
  output logic comp_in,
  input wire logic serial_out,
  input wire logic serial_oe_n,
  input wire logic sample_en,
  input wire logic [RES_BITS-1:0] dac_code
);
  logic [RES_BITS-1:0] vin;
  logic oe [0:31];
  logic dout [0:31];
  logic se [0:31];

  // Idle host: deselected, clock parked low.
  initial begin
    select_shutdown_n = 1'b1;
    transfer_conv_clock = 1'b0;
    comp_in = 1'b0;
    vin = '0;
  end

  // Ideal comparator, so the finished code must equal the held input value.
  always @(negedge mclk) begin
    comp_in <= (dac_code <= vin);
  end

  // One frame; 40 mclk per phase gives 160 ns high and low, about 3.1 MHz, inside the host's rate limit.
  task automatic frame(input logic [RES_BITS-1:0] v, input int n, input logic go);
    vin = v;
    @(negedge mclk) select_shutdown_n = !go;
    repeat (HALF) @(negedge mclk);
    se[0] = sample_en;
    for (int k = 1; k <= n; k++) begin
      transfer_conv_clock = 1'b1;
      repeat (HALF) @(negedge mclk);
      transfer_conv_clock = 1'b0;
      repeat (HALF) @(negedge mclk);
      oe[k] = serial_oe_n;
      // A floating pin has no keeper here, so the model reads the inverse of the last value.
      dout[k] = serial_oe_n ? !serial_out : serial_out;
      se[k] = sample_en;
    end
    select_shutdown_n = 1'b1;
    repeat (HALF) @(negedge mclk);
  endtask
endmodule

`default_nettype wire

// ### dv/sar_adc_serial_readout_bench.sv
// Self-checking bench for the converter readout: word order, framing, abort, buffer back-pressure.
// Assumes the host model above drives the pins; the bench drives reset and the result consumer.
`timescale 1ns/10ps
`default_nettype none

module sar_adc_serial_readout_bench;
  import sar_pkg::*;
  logic mclk, rst_n, sel_n, dclk, comp, sout, soe_n, sen, shd, rvalid, rready;
  logic [RES_BITS-1:0] dac;
  sar_result_t rword;
  int n_errors = 0;
  int checked = 0;
  logic [11:0] pats [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h3c1};

  sar_adc_serial_readout uut (.mclk(mclk), .rst_n(rst_n), .select_shutdown_n(sel_n),
    .transfer_conv_clock(dclk), .comp_in(comp), .serial_out(sout), .serial_oe_n(soe_n),
    .sample_en(sen), .dac_code(dac), .shutdown(shd), .res_word(rword), .res_valid(rvalid),
    .res_ready(rready));

  sar_host_model host (.mclk(mclk), .select_shutdown_n(sel_n), .transfer_conv_clock(dclk),
    .comp_in(comp), .serial_out(sout), .serial_oe_n(soe_n), .sample_en(sen), .dac_code(dac));

  // Clock at 250 MHz.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Takes one word from the result stream, waiting a bounded time for it.
  task automatic pop(input logic [11:0] exp);
    int w;
    w = 0;
    while (rvalid !== 1'b1 && w < 20) begin
      @(negedge mclk);
      w++;
    end
    check(rvalid, 1'b1);
    check(rword.code, exp);
    rready = 1'b1;
    @(negedge mclk) rready = 1'b0;
    // One idle cycle keeps back-to-back pops from raising ready again in the same step.
    @(negedge mclk);
  endtask

  task automatic t_reset;
    check({soe_n, shd, rvalid, sen}, 12'hc);
  endtask

  // Full frame with extra clocks past the reversed word.
  // Mid-sample look: select is low, so the core is awake and the trial code is clear.
  task automatic mid_check;
    repeat (20) @(negedge mclk);
    check(shd, 1'b0);
    check(dac, 12'h000);
  endtask

  task automatic t_word(input logic [11:0] v);
    fork
      host.frame(v, 28, 1'b1);
      mid_check;
    join
    check(dac, v);
    check({host.se[0], host.se[1], host.se[2]}, 12'h6);
    check({host.oe[1], host.dout[2]}, 12'h2);
    for (int k = 2; k <= 25; k++)
      check(host.oe[k], 1'b0);
    for (int k = 0; k < 12; k++)
      check(host.dout[3 + k], v[11 - k]);
    for (int k = 1; k < 12; k++)
      check(host.dout[14 + k], v[k]);
    check({host.oe[26], host.oe[27], host.oe[28]}, 12'h7);
    pop(v);
  endtask

  // Select rises mid-word, then clocks arrive while deselected.
  task automatic t_abort;
    host.frame(12'h5a5, 8, 1'b1);
    check(host.oe[8], 1'b0);
    check({soe_n, shd}, 12'h3);
    repeat (8) @(negedge mclk);
    check(rvalid, 1'b0);
    host.frame(12'h5a5, 4, 1'b0);
    check({host.oe[2], host.oe[3], shd}, 12'h7);
  endtask

  // Seventeen words fill memory and output stage; the next start is refused.
  task automatic t_full;
    for (int i = 0; i < FIFO_DEPTH + 1; i++)
      host.frame(12'(i * 151), 14, 1'b1);
    host.frame(12'h7ff, 14, 1'b1);
    check({host.oe[2], host.oe[3], shd}, 12'h7);
    for (int i = 0; i < FIFO_DEPTH + 1; i++)
      pop(12'(i * 151));
    repeat (4) @(negedge mclk);
    check(rvalid, 1'b0);
  endtask

  task automatic summarize;
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence; reset is held for two cycles and checked while held.
  initial begin
    rst_n = 1'b0;
    rready = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset;
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    foreach (pats[i])
      t_word(pats[i]);
    t_abort;
    t_word(12'h801);
    t_full;
    summarize;
  end

  // Watchdog: the tests need about 35000 cycles, so this leaves ample margin.
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    summarize;
  end
endmodule

`default_nettype wire
